// File: logic/bridge_regs_params.svh
`ifndef BRIDGE_REGS_PARAMS_SVH
`define BRIDGE_REGS_PARAMS_SVH

// ----------------------------------------------------------------------------
// Configuration space placement
// ----------------------------------------------------------------------------
// Byte offsets of the two registers and the dword that holds both.
`define CMD_OFFSET 8'h04
`define STS_OFFSET 8'h06
`define CMD_DWORD_IDX 6'h01

// ----------------------------------------------------------------------------
// Command register fields
// ----------------------------------------------------------------------------
`define CMD_IO_SPACE_EN 0
`define CMD_MEMORY_SPACE_EN 1
`define CMD_BUS_MASTER_ACCEPT_EN 2
`define CMD_SPECIAL_CYCLE_EN 3
`define CMD_POSTABLE_WRITE_EN 4
`define CMD_PALETTE_SNOOP 5
`define CMD_PARITY_RESP_EN 6
`define CMD_SYSTEM_ERROR_REPORT_EN 8
`define CMD_RESET 16'h0000
`define CMD_WRITABLE_MASK 16'h0147

// ----------------------------------------------------------------------------
// Primary status register fields
// ----------------------------------------------------------------------------
`define STS_DETECTED_PARITY_ERR 15
`define STS_SYSTEM_ERROR_SEEN 14
`define STS_RESET 16'h0080
`define STS_FIXED_MASK 16'h3FFF

// ----------------------------------------------------------------------------
// Sticky flag slots inside the flag bank
// ----------------------------------------------------------------------------
`define FLAG_PARITY_ERR 0
`define FLAG_SYSTEM_ERR 1
`define FLAG_COUNT 2

`endif

// File: logic/bridge_regs_pkg.sv
package bridge_regs_pkg;
  // A 16-bit configuration register image.
  typedef logic [15:0] reg16_t;
  // A configuration dword as carried on the access port.
  typedef logic [31:0] cfg_dword_t;
  // Byte enables of one configuration dword.
  typedef logic [3:0] cfg_be_t;
endpackage

// File: logic/status_flag_if.sv
`timescale 1ns/1ns
// Carries set events and clear requests to the flag bank, and the stored flags back from it.
interface status_flag_if #(
  parameter int N = 2
);
  logic [N-1:0] set;
  logic [N-1:0] clr;
  logic [N-1:0] flag;
  modport owner (output set, output clr, input flag);
  modport bank (input set, input clr, output flag);
endinterface

// File: logic/sticky_flag_bank.sv
`timescale 1ns/1ns
`include "bridge_regs_params.svh"

// ----------------------------------------------------------------------------
// Sticky write-one-to-clear flags
// ----------------------------------------------------------------------------
module sticky_flag_bank #(
  parameter int N = 2
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  status_flag_if.bank flags
);
  import bridge_regs_pkg::*;

  logic [N-1:0] flag_r;

  // A set in the same cycle as a clear wins, so no event is lost.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      flag_r <= '0;
    end else begin
      flag_r <= (flag_r & ~flags.clr) | flags.set;
    end
  end

  assign flags.flag = flag_r;
endmodule // sticky_flag_bank

// File: logic/bridge_command_status_regs.sv
`timescale 1ns/1ns
`include "bridge_regs_params.svh"

// Operation
// - Palette snoop command bit reads zero and cannot be written.
// - Postable memory write enable bit reads zero and cannot be written.
// - Special cycle enable bit reads zero; writes have no effect.
// - PCI-originated cycles are accepted only while bus master accept is one.
// - Configuration address and data port accesses pass regardless of bus master accept.
// - Memory space enable is stored only; hub memory cycles always go to PCI.
// - I/O space enable stored only; hub I/O goes to PCI except USB/IDE.
// - Status resets to 0080h; writing one clears a writable bit, zero keeps it.
// - Detected parity error sets on hub parity error regardless of parity response.
// - External PCI parity error also sets primary and secondary detected parity bits.
// - System error seen sets on PCI address/command/special-cycle parity error with response on.
// - System error seen with report enable raises NMI, or SMI when routed there.
// - Parity response bit one reports hub parity errors; zero ignores them.
module bridge_command_status_regs #(
  parameter bit EXT_PERR_SETS_PARITY = 1'b1
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic cfg_wr_in,
  input wire logic cfg_rd_in,
  input wire logic [5:0] cfg_dword_in,
  input wire bridge_regs_pkg::cfg_be_t cfg_be_in,
  input wire bridge_regs_pkg::cfg_dword_t cfg_wdata_in,
  output bridge_regs_pkg::cfg_dword_t cfg_rdata_out,
  output logic cfg_rvalid_out,
  input wire logic pci_cycle_req_in,
  input wire logic pci_cycle_cfg_port_in,
  output logic pci_cycle_accept_out,
  input wire logic hub_mem_cycle_in,
  output logic hub_mem_fwd_out,
  input wire logic hub_io_cycle_in,
  input wire logic hub_io_usb_ide_in,
  output logic hub_io_fwd_out,
  input wire logic hub_parity_err_in,
  output logic hub_parity_report_out,
  input wire logic pci_ext_perr_in,
  output logic secondary_parity_set_out,
  input wire logic pci_addr_parity_err_in,
  input wire logic pci_cmd_parity_err_in,
  input wire logic pci_sc_data_parity_err_in,
  input wire logic nmi_route_smi_in,
  output logic nmi_out,
  output logic system_mgmt_irq_n_out,
  output bridge_regs_pkg::reg16_t bridge_command_out,
  output bridge_regs_pkg::reg16_t primary_device_status_out
);
  import bridge_regs_pkg::*;

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // Expands two byte enables into a 16-bit lane mask.
  function automatic reg16_t lane_mask(input logic [1:0] be);
    lane_mask = {{8{be[1]}}, {8{be[0]}}};
  endfunction

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  reg16_t cmd_r;
  reg16_t cmd_nxt;
  reg16_t sts_view;
  reg16_t sts_clr_mask;
  logic hit;
  logic cmd_wr;
  logic sts_wr;
  logic bus_master_accept_en;
  logic parity_resp_en;
  logic system_error_report_en;
  logic detected_parity_err;
  logic system_error_seen;
  logic pci_parity_event;
  logic parity_flag_set;
  logic syserr_flag_set;

  status_flag_if #(.N(`FLAG_COUNT)) flag_bus ();

  sticky_flag_bank #(.N(`FLAG_COUNT)) u_flags (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .flags(flag_bus.bank)
  );

  // --------------------------------------------------------------------------
  // Configuration access decode
  // --------------------------------------------------------------------------
  // Command and status share the dword at byte offset 04h.
  assign hit = cfg_dword_in == `CMD_DWORD_IDX;
  assign cmd_wr = cfg_wr_in && hit && (cfg_be_in[1:0] != 2'h0);
  assign sts_wr = cfg_wr_in && hit && (cfg_be_in[3:2] != 2'h0);

  // --------------------------------------------------------------------------
  // Command register
  // --------------------------------------------------------------------------
  // Only the stored bits take write data; hardwired bits stay zero.
  always_comb begin
    cmd_nxt = cmd_r;
    if (cmd_wr) begin
      cmd_nxt = (cmd_r & ~lane_mask(cfg_be_in[1:0]))
              | (cfg_wdata_in[15:0] & lane_mask(cfg_be_in[1:0])); 
      cmd_nxt = cmd_nxt & `CMD_WRITABLE_MASK;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cmd_r <= `CMD_RESET;
    end else begin
      cmd_r <= cmd_nxt;
    end
  end

  assign bus_master_accept_en = cmd_r[`CMD_BUS_MASTER_ACCEPT_EN];
  assign parity_resp_en = cmd_r[`CMD_PARITY_RESP_EN];
  assign system_error_report_en = cmd_r[`CMD_SYSTEM_ERROR_REPORT_EN];

  // --------------------------------------------------------------------------
  // Cycle steering
  // --------------------------------------------------------------------------
  // Configuration port cycles bypass the bus master gate.
  assign pci_cycle_accept_out = pci_cycle_req_in && (bus_master_accept_en || pci_cycle_cfg_port_in);
  // Memory and I/O space enables are readback only.
  assign hub_mem_fwd_out = hub_mem_cycle_in;
  assign hub_io_fwd_out = hub_io_cycle_in && !hub_io_usb_ide_in;

  // --------------------------------------------------------------------------
  // Status flag events
  // --------------------------------------------------------------------------
  // External parity errors may set the flags spuriously; firmware clears them.
  assign parity_flag_set = hub_parity_err_in || (EXT_PERR_SETS_PARITY && pci_ext_perr_in);
  assign pci_parity_event = pci_addr_parity_err_in || pci_cmd_parity_err_in || pci_sc_data_parity_err_in;
  assign syserr_flag_set = pci_parity_event && parity_resp_en;
  // Only the two sticky bits take write-one-to-clear data.
  assign sts_clr_mask = sts_wr ? (cfg_wdata_in[31:16] & lane_mask(cfg_be_in[3:2]) & ~`STS_FIXED_MASK) : 16'h0000;
  assign flag_bus.set[`FLAG_PARITY_ERR] = parity_flag_set;
  assign flag_bus.set[`FLAG_SYSTEM_ERR] = syserr_flag_set;
  assign flag_bus.clr[`FLAG_PARITY_ERR] = sts_clr_mask[`STS_DETECTED_PARITY_ERR];
  assign flag_bus.clr[`FLAG_SYSTEM_ERR] = sts_clr_mask[`STS_SYSTEM_ERROR_SEEN];
  assign detected_parity_err = flag_bus.flag[`FLAG_PARITY_ERR];
  assign system_error_seen = flag_bus.flag[`FLAG_SYSTEM_ERR];

  // Fixed status bits always show their reset value.
  always_comb begin
    sts_view = `STS_RESET & `STS_FIXED_MASK;
    sts_view[`STS_DETECTED_PARITY_ERR] = detected_parity_err;
    sts_view[`STS_SYSTEM_ERROR_SEEN] = system_error_seen;
  end

  // --------------------------------------------------------------------------
  // Error signalling
  // --------------------------------------------------------------------------
  // Hub parity errors are reported onward only while parity response is on.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      hub_parity_report_out <= 1'b0;
    end else begin
      hub_parity_report_out <= hub_parity_err_in && parity_resp_en;
    end
  end

  // External parity errors also mark the secondary status register.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      secondary_parity_set_out <= 1'b0;
    end else begin
      secondary_parity_set_out <= EXT_PERR_SETS_PARITY && pci_ext_perr_in;
    end
  end

  // The system error level drives NMI, or the low-active SMI when routed there.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      nmi_out <= 1'b0;
      system_mgmt_irq_n_out <= 1'b1;
    end else begin
      nmi_out <= system_error_seen && system_error_report_en && !nmi_route_smi_in;
      system_mgmt_irq_n_out <= !(system_error_seen && system_error_report_en && nmi_route_smi_in);
    end
  end

  // --------------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------------
  // Reads answer one cycle later; other dwords read as zero.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cfg_rdata_out <= 32'h0000_0000;
      cfg_rvalid_out <= 1'b0;
    end else begin
      cfg_rvalid_out <= cfg_rd_in;
      if (cfg_rd_in) begin
        cfg_rdata_out <= hit ? {sts_view, cmd_r} : 32'h0000_0000;
      end
    end
  end

  assign bridge_command_out = cmd_r;
  assign primary_device_status_out = sts_view;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  a_palette_snoop_zero: assert property (
    cfg_rvalid_out && $past(hit) |-> !cfg_rdata_out[`CMD_PALETTE_SNOOP])
    else $error("palette snoop bit read as one");

  a_postable_write_zero: assert property (
    !cmd_r[`CMD_POSTABLE_WRITE_EN])
    else $error("postable write enable bit is set");

  a_special_cycle_zero: assert property (
    cmd_wr && cfg_wdata_in[`CMD_SPECIAL_CYCLE_EN] |=> !cmd_r[`CMD_SPECIAL_CYCLE_EN])
    else $error("special cycle enable took write data");

  a_master_gate_closed: assert property (
    pci_cycle_req_in && !pci_cycle_cfg_port_in && !cmd_r[`CMD_BUS_MASTER_ACCEPT_EN] |-> !pci_cycle_accept_out)
    else $error("PCI cycle accepted with bus master accept off");

  a_master_gate_open: assert property (
    pci_cycle_req_in && cmd_r[`CMD_BUS_MASTER_ACCEPT_EN] |-> pci_cycle_accept_out)
    else $error("PCI cycle refused after bus master accept set");

  a_cfg_port_pass: assert property (
    pci_cycle_req_in && pci_cycle_cfg_port_in |-> pci_cycle_accept_out)
    else $error("configuration port access blocked");

  a_mem_forward: assert property (
    hub_mem_cycle_in && !cmd_r[`CMD_MEMORY_SPACE_EN] |-> hub_mem_fwd_out)
    else $error("hub memory cycle not forwarded");

  a_io_forward: assert property (
    hub_io_cycle_in |-> hub_io_fwd_out == !hub_io_usb_ide_in)
    else $error("hub I/O forwarding wrong");

  a_w1c_clear: assert property (
    sts_wr && cfg_be_in[3] && cfg_wdata_in[31] && !parity_flag_set |=> !detected_parity_err)
    else $error("detected parity bit not cleared by write of one");

  a_w1c_keep: assert property (
    detected_parity_err && !(sts_wr && cfg_be_in[3] && cfg_wdata_in[31]) |=> detected_parity_err)
    else $error("detected parity bit lost without a clear");

  a_parity_always_sets: assert property (
    hub_parity_err_in |=> detected_parity_err [*2] or (detected_parity_err ##1 $past(sts_clr_mask[15])))
    else $error("hub parity error did not set detected parity bit");

  a_ext_perr_both: assert property (
    pci_ext_perr_in && EXT_PERR_SETS_PARITY |=> detected_parity_err && secondary_parity_set_out)
    else $error("external parity error missed a status register");

  a_syserr_sets: assert property (
    pci_parity_event && cmd_r[`CMD_PARITY_RESP_EN] |=> system_error_seen)
    else $error("PCI parity error did not set system error seen");

  a_syserr_needs_resp: assert property (
    !system_error_seen && !(pci_parity_event && cmd_r[`CMD_PARITY_RESP_EN]) |=> !system_error_seen)
    else $error("system error seen set without cause");

  a_nmi_raise: assert property (
    system_error_seen && cmd_r[`CMD_SYSTEM_ERROR_REPORT_EN] && !nmi_route_smi_in |=> nmi_out && system_mgmt_irq_n_out)
    else $error("NMI not raised on system error");

  a_smi_raise: assert property (
    system_error_seen && cmd_r[`CMD_SYSTEM_ERROR_REPORT_EN] && nmi_route_smi_in |=> !system_mgmt_irq_n_out && !nmi_out)
    else $error("SMI not raised on routed system error");

  a_parity_report: assert property (
    hub_parity_err_in |=> hub_parity_report_out == $past(parity_resp_en))
    else $error("hub parity report does not follow parity response");

  a_fixed_bits: assert property (
    (cmd_r & ~`CMD_WRITABLE_MASK) == 16'h0000 && (sts_view & `STS_FIXED_MASK) == (`STS_RESET & `STS_FIXED_MASK))
    else $error("hardwired field changed");
endmodule // bridge_command_status_regs

// File: sim/bus_agent_model.sv
`timescale 1ns/1ns

// ----------------------------------------------------------------------------
// Hub and PCI agents facing the bridge registers
// ----------------------------------------------------------------------------
// Turns the bench's requests into the error events and cycle levels that the bridge sees.
module bus_agent_model (
  input wire logic [4:0] err_req_in,
  input wire logic [4:0] cyc_req_in,
  output logic [4:0] err_out,
  output logic [4:0] cyc_out
);
  // Event slots: 0 hub parity, 1 external parity, 2 address, 3 command, 4 special-cycle data.
  // Cycle levels: {pci request, config port access, hub memory, hub I/O, USB or IDE target}.
  // Error events pass straight through; the bench sets their timing.
  assign err_out = err_req_in;

  // A port access exists only inside a PCI request, a USB or IDE target only inside hub I/O.
  assign cyc_out[4] = cyc_req_in[4];
  assign cyc_out[3] = cyc_req_in[4] && cyc_req_in[3];
  assign cyc_out[2:1] = cyc_req_in[2:1];
  assign cyc_out[0] = cyc_req_in[1] && cyc_req_in[0];
endmodule // bus_agent_model

// File: sim/bridge_command_status_regs_tb.sv
`timescale 1ns/1ns

// ----------------------------------------------------------------------------
// Bench for the bridge command and status registers
// ----------------------------------------------------------------------------
module bridge_command_status_regs_tb;
  import bridge_regs_pkg::*;
  localparam int DLY = 1;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic cfg_wr = 1'b0;
  logic cfg_rd = 1'b0;
  logic [5:0] cfg_dword = 6'h00;
  cfg_be_t cfg_be = 4'h0;
  cfg_dword_t cfg_wdata = 32'h0000_0000;
  logic smi_route = 1'b0;
  cfg_dword_t cfg_rdata;
  logic cfg_rvalid, accept, mem_fwd, io_fwd, report, sec_set, nmi, smi_n;
  logic [4:0] err, cyc;
  logic [4:0] err_req = 5'h00;
  logic [4:0] cyc_req = 5'h00;
  reg16_t cmd_img, sts_img;
  int errors = 0;
  int compares = 0;

  // Free-running 25 MHz clock.
  always #20 clk_in = ~clk_in;

  bus_agent_model agent (.err_req_in(err_req), .cyc_req_in(cyc_req), .err_out(err), .cyc_out(cyc));

  bridge_command_status_regs dut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .cfg_wr_in(cfg_wr), .cfg_rd_in(cfg_rd),
    .cfg_dword_in(cfg_dword), .cfg_be_in(cfg_be), .cfg_wdata_in(cfg_wdata),
    .cfg_rdata_out(cfg_rdata), .cfg_rvalid_out(cfg_rvalid),
    .pci_cycle_req_in(cyc[4]), .pci_cycle_cfg_port_in(cyc[3]), .pci_cycle_accept_out(accept),
    .hub_mem_cycle_in(cyc[2]), .hub_mem_fwd_out(mem_fwd), .hub_io_cycle_in(cyc[1]),
    .hub_io_usb_ide_in(cyc[0]), .hub_io_fwd_out(io_fwd), .hub_parity_err_in(err[0]),
    .hub_parity_report_out(report), .pci_ext_perr_in(err[1]), .secondary_parity_set_out(sec_set),
    .pci_addr_parity_err_in(err[2]), .pci_cmd_parity_err_in(err[3]), .pci_sc_data_parity_err_in(err[4]),
    .nmi_route_smi_in(smi_route), .nmi_out(nmi), .system_mgmt_irq_n_out(smi_n),
    .bridge_command_out(cmd_img), .primary_device_status_out(sts_img)
  );

  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One configuration write; the effect is visible once the task returns.
  task automatic wr(input cfg_be_t be, input cfg_dword_t d, input logic [5:0] idx = 6'h01);
    @(posedge clk_in);
    #DLY;
    cfg_wr = 1'b1;
    cfg_dword = idx;
    cfg_be = be;
    cfg_wdata = d;
    @(posedge clk_in);
    #DLY;
    cfg_wr = 1'b0;
  endtask

  // One configuration read; data and valid stand for the cycle after the strobe.
  task automatic rd_chk(input cfg_dword_t exp, input string what, input logic [5:0] idx = 6'h01);
    @(posedge clk_in);
    #DLY;
    cfg_rd = 1'b1;
    cfg_dword = idx;
    @(posedge clk_in);
    #DLY;
    cfg_rd = 1'b0;
    chk({31'h0, cfg_rvalid}, 32'h1, "read valid");
    chk(cfg_rdata, exp, what);
  endtask

  // Raises one far-side error event for exactly one clock.
  task automatic pulse(input int idx);
    @(posedge clk_in);
    #DLY;
    err_req[idx] = 1'b1;
    @(posedge clk_in);
    #DLY;
    err_req[idx] = 1'b0;
  endtask

  // Changes the far-side cycle levels just after an edge.
  task automatic drive(input logic [4:0] v);
    @(posedge clk_in);
    #DLY;
    cyc_req = v;
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic end_of_test;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Cuts a hung run short.
  initial begin
    repeat (20000) @(posedge clk_in);
    errors++;
    $display("[ERR] %0t run limit reached", $time);
    end_of_test();
  end

  // Main sequence of tests.
  initial begin
    repeat (20) @(posedge clk_in);
    #DLY;
    sys_rst_in = 1'b0;
    rd_chk(32'h0080_0000, "reset image");
    $display("test reset done");
    wr(4'h3, 32'h0000_FFFF);
    rd_chk(32'h0080_0147, "command mask");
    chk({29'h0, cmd_img[5:3]}, 32'h0, "hardwired bits");
    wr(4'h2, 32'hFFFF_0000);
    rd_chk(32'h0080_0047, "high lane cleared");
    wr(4'hF, 32'hFFFF_FFFF, 6'h02);
    rd_chk(32'h0000_0000, "unmapped dword", 6'h02);
    wr(4'hC, 32'h3FFF_0000);
    rd_chk(32'h0080_0047, "status fixed bits");
    $display("test command done");
    wr(4'h3, 32'h0000_0000);
    drive(5'h10);
    #DLY chk({29'h0, accept, mem_fwd, io_fwd}, 32'h0, "master off");
    drive(5'h18);
    #DLY chk({29'h0, accept, mem_fwd, io_fwd}, 32'h4, "config port");
    drive(5'h06);
    #DLY chk({29'h0, accept, mem_fwd, io_fwd}, 32'h3, "hub forward");
    drive(5'h03);
    #DLY chk({29'h0, accept, mem_fwd, io_fwd}, 32'h0, "usb ide io");
    wr(4'h1, 32'h0000_0004);
    drive(5'h10);
    #DLY chk({29'h0, accept, mem_fwd, io_fwd}, 32'h4, "master on");
    $display("test cycles done");
    wr(4'h1, 32'h0000_0000);
    pulse(0);
    chk({16'h0, sts_img}, 32'h8080, "parity flag");
    chk({31'h0, report}, 32'h0, "report off");
    wr(4'h8, 32'h0000_0000);
    rd_chk(32'h8080_0000, "zero keeps flag");
    wr(4'h8, 32'h8000_0000);
    rd_chk(32'h0080_0000, "flag cleared");
    wr(4'h1, 32'h0000_0040);
    pulse(0);
    chk({31'h0, report}, 32'h1, "report on");
    wr(4'h8, 32'h8000_0000);
    pulse(1);
    chk({31'h0, sec_set}, 32'h1, "secondary set");
    chk({16'h0, sts_img}, 32'h8080, "external parity flag");
    wr(4'h8, 32'h8000_0000);
    $display("test parity done");
    wr(4'h1, 32'h0000_0000);
    pulse(2);
    chk({16'h0, sts_img}, 32'h0080, "no response");
    wr(4'h3, 32'h0000_0140);
    for (int i = 2; i <= 4; i++) begin
      smi_route = (i == 4);
      pulse(i);
      chk({16'h0, sts_img}, 32'h4080, "system error flag");
      chk({30'h0, nmi, smi_n}, 32'h1, "not yet raised");
      @(posedge clk_in);
      #DLY chk({30'h0, nmi, smi_n}, (i == 4) ? 32'h0 : 32'h3, "nmi or smi");
      wr(4'h8, 32'h4000_0000);
    end
    $display("test system error done");
    @(posedge clk_in);
    #DLY sys_rst_in = 1'b1;
    @(posedge clk_in);
    #DLY sys_rst_in = 1'b0;
    chk({cmd_img, sts_img}, 32'h0000_0080, "second reset");
    $display("test second reset done");
    end_of_test();
  end
endmodule // bridge_command_status_regs_tb
